//--- hw/flash_host_pkg.sv
package flash_host_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESUME_GAP_MS = 4;
  localparam int RESUME_GAP_CYCLES = (RESUME_GAP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_SUSPEND_PAIRS = 1024;
  localparam int WE_PULSE_NS = 35;
  localparam int WE_PULSE_CYCLES = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_NS = 70;
  localparam int SYNC_STAGES = 3;
  localparam int READ_WAIT_CYCLES =
    (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;

  // ----------------------------------------------------------------
  // user command codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_PROGRAM = 3'h1;
  localparam logic [2:0] CMD_SUSPEND = 3'h2;
  localparam logic [2:0] CMD_RESUME = 3'h3;
  localparam logic [2:0] CMD_ID_ENTRY = 3'h4;
  localparam logic [2:0] CMD_QUERY_ENTRY = 3'h5;
  localparam logic [2:0] CMD_RESET = 3'h6;

  // ----------------------------------------------------------------
  // flash command data and addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] DATA_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] DATA_UNLOCK2 = 16'h0055;
  localparam logic [15:0] DATA_PROGRAM = 16'h00a0;
  localparam logic [15:0] DATA_ID_ENTRY = 16'h0090;
  localparam logic [15:0] DATA_QUERY = 16'h0098;
  localparam logic [15:0] DATA_RESET = 16'h00f0;
  localparam logic [15:0] DATA_SUSPEND = 16'h00b0;
  localparam logic [15:0] DATA_RESUME = 16'h0030;
  localparam logic [20:0] ADDR_UNLOCK1_WORD = 21'h000555;
  localparam logic [20:0] ADDR_UNLOCK2_WORD = 21'h0002aa;
  localparam logic [20:0] ADDR_QUERY_WORD = 21'h000055;
  localparam logic [20:0] ADDR_UNLOCK1_BYTE = 21'h000aaa;
  localparam logic [20:0] ADDR_UNLOCK2_BYTE = 21'h000555;
  localparam logic [20:0] ADDR_QUERY_BYTE = 21'h0000aa;

  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int TIME_LIMIT_POS = 5;

endpackage

//--- hw/flash_bus_cycle.sv
`timescale 1ns/100ps
module flash_bus_cycle (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // cycle request
  input wire logic start,
  input wire logic write_en,
  input wire logic [20:0] addr,
  input wire logic [15:0] wdata,
  input wire logic byte_mode,
  output logic done,
  output logic [15:0] rdata,
  // flash pins
  output logic [19:0] flash_addr,
  output logic flash_addr_lsb,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe
);

  typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_READ} cyc_state_type;

  cyc_state_type state_r;
  logic [15:0] dq_s1_r;
  logic [15:0] dq_s2_r;
  logic [15:0] dq_s3_r;
  logic [3:0] cnt_r;

  // ----------------------------------------------------------------
  // data pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
      dq_s3_r <= 16'h0000;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // cycle sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= C_IDLE;
      cnt_r <= 4'h0;
      done <= 1'b0;
      rdata <= 16'h0000;
      flash_addr <= 20'h00000;
      flash_addr_lsb <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        C_IDLE: begin
          if (start) begin
            flash_addr <= byte_mode ? addr[20:1] : addr[19:0];
            flash_addr_lsb <= byte_mode ? addr[0] : 1'b0;
            flash_ce_n <= 1'b0;
            cnt_r <= 4'h0;
            if (write_en) begin
              dq_out <= byte_mode ? {8'h00, wdata[7:0]} : wdata;
              dq_oe <= 1'b1;
              state_r <= C_SETUP;
            end else begin
              flash_oe_n <= 1'b0;
              state_r <= C_READ;
            end
          end
        end
        C_SETUP: begin
          flash_we_n <= 1'b0;
          cnt_r <= 4'(flash_host_pkg::WE_PULSE_CYCLES - 1);
          state_r <= C_STROBE;
        end
        C_STROBE: begin
          if (cnt_r == 4'h0) begin
            flash_we_n <= 1'b1;
            state_r <= C_HOLD;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        C_HOLD: begin
          flash_ce_n <= 1'b1;
          dq_oe <= 1'b0;
          done <= 1'b1;
          state_r <= C_IDLE;
        end
        C_READ: begin
          if (cnt_r >= 4'(flash_host_pkg::READ_WAIT_CYCLES) && dq_s2_r == dq_s3_r) begin
            rdata <= byte_mode ? {8'h00, dq_s3_r[7:0]} : dq_s3_r;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            done <= 1'b1;
            state_r <= C_IDLE;
          end else if (cnt_r != 4'hf) begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: begin
          state_r <= C_IDLE;
        end
      endcase
    end
  end

endmodule // flash_bus_cycle

//--- hw/flash_host_ctrl.sv
`timescale 1ns/100ps
// How it works
// - wait 4ms from resume to next suspend
// - at most 1024 suspend-resume pairs per erase
// - two unlocks then 90h enter identification
// - after time limit failure, issue reset
// - query entry writes 98h at 55h/AAh
module flash_host_ctrl #(
  parameter int RESUME_GAP = flash_host_pkg::RESUME_GAP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user commands
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_code,
  input wire logic [20:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic byte_mode,
  // user responses and status
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic suspended,
  output logic resume_hold,
  output logic pair_limit,
  output logic fail_recovering,
  // flash pins
  output logic [19:0] flash_addr,
  output logic flash_addr_lsb,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_byte_n,
  output logic flash_reset_n,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic ready_busy_in
);

  typedef enum logic [2:0] {S_IDLE, S_WRITE, S_WAIT_W, S_READ, S_WAIT_R} seq_state_type;

  seq_state_type state_r;
  logic [2:0] code_r;
  logic [20:0] addr_r;
  logic [15:0] data_r;
  logic [1:0] step_r;
  logic fail_pending_r;
  logic suspended_r;
  logic [15:0] gap_cnt_r;
  logic [10:0] pairs_r;
  logic rb_s1_r;
  logic rb_s2_r;
  logic rb_s3_r;
  logic rb_r;
  logic cyc_start;
  logic cyc_write;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic [36:0] step_word;
  logic seq_done;
  logic cmd_allowed;
  logic accept;

  // ----------------------------------------------------------------
  // sequence tables
  // ----------------------------------------------------------------
  function automatic logic [2:0] seq_len(input logic [2:0] code);
    case (code)
      flash_host_pkg::CMD_PROGRAM: seq_len = 3'h4;
      flash_host_pkg::CMD_ID_ENTRY: seq_len = 3'h3;
      flash_host_pkg::CMD_READ: seq_len = 3'h0;
      default: seq_len = 3'h1;
    endcase
  endfunction

  function automatic logic [36:0] seq_step(input logic [2:0] code, input logic [1:0] idx,
                                           input logic [20:0] a, input logic [15:0] d,
                                           input logic bm);
    logic [20:0] u1;
    logic [20:0] u2;
    logic [20:0] q;
    u1 = bm ? flash_host_pkg::ADDR_UNLOCK1_BYTE : flash_host_pkg::ADDR_UNLOCK1_WORD;
    u2 = bm ? flash_host_pkg::ADDR_UNLOCK2_BYTE : flash_host_pkg::ADDR_UNLOCK2_WORD;
    q = bm ? flash_host_pkg::ADDR_QUERY_BYTE : flash_host_pkg::ADDR_QUERY_WORD;
    if ((code == flash_host_pkg::CMD_PROGRAM || code == flash_host_pkg::CMD_ID_ENTRY)
        && idx == 2'h0) begin
      seq_step = {u1, flash_host_pkg::DATA_UNLOCK1};
    end else if ((code == flash_host_pkg::CMD_PROGRAM || code == flash_host_pkg::CMD_ID_ENTRY)
                 && idx == 2'h1) begin
      seq_step = {u2, flash_host_pkg::DATA_UNLOCK2};
    end else begin
      case (code)
        flash_host_pkg::CMD_PROGRAM:
          seq_step = (idx == 2'h2) ? {u1, flash_host_pkg::DATA_PROGRAM} : {a, d};
        flash_host_pkg::CMD_ID_ENTRY: seq_step = {u1, flash_host_pkg::DATA_ID_ENTRY};
        flash_host_pkg::CMD_QUERY_ENTRY: seq_step = {q, flash_host_pkg::DATA_QUERY};
        flash_host_pkg::CMD_SUSPEND: seq_step = {a, flash_host_pkg::DATA_SUSPEND};
        flash_host_pkg::CMD_RESUME: seq_step = {a, flash_host_pkg::DATA_RESUME};
        default: seq_step = {a, flash_host_pkg::DATA_RESET};
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // ready/busy synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
      rb_s3_r <= 1'b1;
      rb_r <= 1'b1;
    end else begin
      rb_s1_r <= ready_busy_in;
      rb_s2_r <= rb_s1_r;
      rb_s3_r <= rb_s2_r;
      if (rb_s2_r == rb_s3_r) begin
        rb_r <= rb_s3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // command acceptance
  // ----------------------------------------------------------------
  always_comb begin
    cmd_allowed = 1'b1;
    if (cmd_code == flash_host_pkg::CMD_SUSPEND) begin
      cmd_allowed = (gap_cnt_r == 16'h0000)
                    && (pairs_r < 11'(flash_host_pkg::MAX_SUSPEND_PAIRS));
    end
  end

  assign cmd_ready = (state_r == S_IDLE) && !fail_pending_r && cmd_allowed;
  assign accept = cmd_valid && cmd_ready;
  assign step_word = seq_step(code_r, step_r, addr_r, data_r, byte_mode);
  assign cyc_start = (state_r == S_WRITE) || (state_r == S_READ);
  assign cyc_write = (state_r == S_WRITE);
  assign seq_done = (state_r == S_WAIT_W) && cyc_done && ({1'b0, step_r} + 3'h1 == seq_len(code_r));
  assign flash_byte_n = !byte_mode;
  assign flash_reset_n = 1'b1;
  assign suspended = suspended_r;
  assign resume_hold = (gap_cnt_r != 16'h0000);
  assign pair_limit = (pairs_r >= 11'(flash_host_pkg::MAX_SUSPEND_PAIRS));
  assign fail_recovering = fail_pending_r;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= S_IDLE;
      code_r <= flash_host_pkg::CMD_READ;
      addr_r <= 21'h000000;
      data_r <= 16'h0000;
      step_r <= 2'h0;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      case (state_r)
        S_IDLE: begin
          step_r <= 2'h0;
          if (fail_pending_r) begin
            code_r <= flash_host_pkg::CMD_RESET;
            state_r <= S_WRITE;
          end else if (accept) begin
            code_r <= cmd_code;
            addr_r <= cmd_addr;
            data_r <= cmd_data;
            state_r <= (seq_len(cmd_code) == 3'h0) ? S_READ : S_WRITE;
          end
        end
        S_WRITE: state_r <= S_WAIT_W;
        S_WAIT_W: begin
          if (seq_done) begin
            state_r <= S_IDLE;
          end else if (cyc_done) begin
            step_r <= step_r + 2'h1;
            state_r <= S_WRITE;
          end
        end
        S_READ: state_r <= S_WAIT_R;
        S_WAIT_R: begin
          if (cyc_done) begin
            rsp_valid <= 1'b1;
            rsp_data <= cyc_rdata;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // failure recovery
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fail_pending_r <= 1'b0;
    end else if (state_r == S_WAIT_R && cyc_done
                 && cyc_rdata[flash_host_pkg::TIME_LIMIT_POS] && !rb_r) begin
      fail_pending_r <= 1'b1;
    end else if (state_r == S_IDLE) begin
      fail_pending_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // suspend bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      suspended_r <= 1'b0;
      gap_cnt_r <= 16'h0000;
      pairs_r <= 11'h000;
    end else begin
      if (seq_done && code_r == flash_host_pkg::CMD_SUSPEND) begin
        suspended_r <= 1'b1;
      end else if (seq_done && code_r == flash_host_pkg::CMD_RESUME) begin
        suspended_r <= 1'b0;
      end
      if (seq_done && code_r == flash_host_pkg::CMD_RESUME) begin
        gap_cnt_r <= 16'(RESUME_GAP);
      end else if (gap_cnt_r != 16'h0000) begin
        gap_cnt_r <= gap_cnt_r - 16'h0001;
      end
      if (seq_done && code_r == flash_host_pkg::CMD_RESUME) begin
        if (pairs_r < 11'(flash_host_pkg::MAX_SUSPEND_PAIRS)) begin
          pairs_r <= pairs_r + 11'h001;
        end
      end else if (gap_cnt_r == 16'h0000 && rb_r && !suspended_r && state_r == S_IDLE) begin
        pairs_r <= 11'h000;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin cycle engine
  // ----------------------------------------------------------------
  flash_bus_cycle u_cycle (
    .clk(clk),
    .rst(rst),
    .start(cyc_start),
    .write_en(cyc_write),
    .addr(state_r == S_READ ? addr_r : step_word[36:16]),
    .wdata(step_word[15:0]),
    .byte_mode(byte_mode),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_addr_lsb(flash_addr_lsb),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .dq_in(dq_in),
    .dq_out(dq_out),
    .dq_oe(dq_oe)
  );

endmodule // flash_host_ctrl

//--- verification/flash_host_ctrl_monitor.sv
`timescale 1ns/100ps
module flash_host_ctrl_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user side
  input wire logic cmd_ready,
  input wire logic [2:0] cmd_code,
  input wire logic rsp_valid,
  input wire logic resume_hold,
  input wire logic pair_limit,
  input wire logic fail_recovering,
  // flash pins
  input wire logic [19:0] flash_addr,
  input wire logic flash_addr_lsb,
  input wire logic flash_we_n,
  input wire logic [15:0] dq_out
);
  // ----------------------------------------------------------------
  // command order checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic susp_offer;
  assign susp_offer = cmd_ready && cmd_code == flash_host_pkg::CMD_SUSPEND;
  a_suspend_gap_wait: assert property (susp_offer |-> !resume_hold)
    else $error("suspend offered in resume gap");
  a_suspend_pair_cap: assert property (susp_offer |-> !pair_limit)
    else $error("suspend offered past pair limit");
  a_id_entry_addr: assert property ($fell(flash_we_n) && dq_out == 16'h0090 |->
    flash_addr == 20'h00555 && !flash_addr_lsb)
    else $error("id entry written at wrong address");
  a_query_entry_addr: assert property ($fell(flash_we_n) && dq_out == 16'h0098 |->
    flash_addr == 20'h00055 && !flash_addr_lsb)
    else $error("query entry written at wrong address");
  a_fail_sends_reset: assert property ($rose(fail_recovering) |->
    ##[1:40] (!flash_we_n && dq_out == 16'h00f0))
    else $error("no reset write after failure");
  a_fail_blocks_cmds: assert property (fail_recovering |-> !cmd_ready)
    else $error("command accepted during failure recovery");
  cover property (rsp_valid);
  cover property ($rose(resume_hold));
  cover property ($rose(pair_limit));
  cover property ($rose(fail_recovering));
endmodule // flash_host_ctrl_monitor

bind flash_host_ctrl flash_host_ctrl_monitor u_monitor (.clk, .rst, .cmd_ready, .cmd_code,
  .rsp_valid, .resume_hold, .pair_limit, .fail_recovering, .flash_addr, .flash_addr_lsb,
  .flash_we_n, .dq_out);

//--- verification/flash_dev_model.sv
`timescale 1ns/100ps
module flash_dev_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h3c, // arbitrary value
  parameter logic [7:0] PROT_SECTOR = 8'h03,
  parameter logic [7:0] ERASE_SECTOR = 8'h05
) (
  // bus pins
  input wire logic [19:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_byte_n,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  output logic [15:0] dq_in = 16'h0,
  output logic ready_busy,
  // scenario controls
  input wire logic erasing,
  input wire logic fail_en,
  input wire logic id_hv
);
  // ----------------------------------------------------------------
  // command decode and read data
  // ----------------------------------------------------------------
  logic [15:0] mem [256];
  logic [15:0] v;
  logic [7:0] d;
  logic [7:0] sec;
  logic [1:0] unl = 2'h0;
  logic in_id = 0, in_qry = 0, susp = 0, busy = 0, fail = 0, tog = 0, pd7 = 0;
  assign sec = flash_addr[19:12];
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
  end
  always @(negedge flash_oe_n) tog = ~tog;
  always @(posedge id_hv) in_id = 1;
  always @(negedge id_hv) in_id = 0;
  always @(posedge busy) begin
    #5000;
    if (!fail) busy = 0;
  end
  always @(posedge flash_we_n) begin
    d = dq_out[7:0];
    if (!flash_ce_n && dq_oe) begin
      if (busy) begin
        if (fail && d == 8'hf0) begin
          busy = 0;
          fail = 0;
        end
      end else if (in_qry) begin
        if (d == 8'hf0) in_qry = 0;
      end else if (in_id) begin
        if (d == 8'hf0) in_id = 0;
        else if (d == 8'h98 && flash_addr == 20'h55) in_qry = 1;
      end else if (unl == 2'h3) begin
        mem[flash_addr[7:0]] = dq_out;
        pd7 = dq_out[7];
        fail = fail_en;
        busy = 1;
        unl = 0;
      end else if (unl == 2'h2 && d == 8'h90) in_id = 1;
      else if (unl == 2'h2 && d == 8'ha0) unl = 3;
      else if (unl == 2'h1 && d == 8'h55 && flash_addr == 20'h2aa) unl = 2;
      else if (d == 8'haa && flash_addr == 20'h555) unl = 1;
      else if (d == 8'h98 && flash_addr == 20'h55) in_qry = 1;
      else if (d == 8'hb0) susp = erasing;
      else if (d == 8'h30) susp = 0;
      if (in_id) unl = 0;
    end
  end
  always_comb begin
    if (in_qry) begin
      case (flash_addr[7:0])
        8'h10: v = 16'h0051;
        8'h11: v = 16'h0052;
        8'h12: v = 16'h0059;
        8'h1f: v = 16'h0004;
        8'h23: v = 16'h0005;
        8'h2c: v = 16'h0004;
        default: v = 16'h0000;
      endcase
    end else if (in_id) begin
      case (flash_addr[1:0])
        2'h0: v = {8'h00, MAKER_CODE};
        2'h1: v = {8'h00, PART_CODE};
        default: v = {15'h0, sec == PROT_SECTOR};
      endcase
    end else if (busy) v = {8'h00, ~pd7, tog, fail, 5'h00};
    else if (susp && sec == ERASE_SECTOR) v = {8'h00, 1'b1, 1'b0, 3'h0, tog, 2'h0};
    else v = mem[flash_addr[7:0]];
  end
  assign ready_busy = !(busy || fail || (erasing && !susp));
  always @(flash_ce_n, flash_oe_n, flash_byte_n, v) begin
    dq_in[7:0] = (!flash_ce_n && !flash_oe_n) ? v[7:0] : ~dq_in[7:0];
    dq_in[15:8] = (!flash_ce_n && !flash_oe_n && flash_byte_n) ? v[15:8] : ~dq_in[15:8];
  end
endmodule // flash_dev_model

//--- verification/flash_host_ctrl_tb.sv
`timescale 1ns/100ps
module flash_host_ctrl_tb;
  // ----------------------------------------------------------------
  // bench, design and device
  // ----------------------------------------------------------------
  logic clk = 0, rst = 1, cmd_valid = 0, byte_mode = 0, erasing = 0, fail_en = 0, id_hv = 0;
  logic cmd_ready, rsp_valid, suspended, resume_hold, pair_limit, fail_recovering, dq_oe;
  logic flash_addr_lsb, flash_ce_n, flash_oe_n, flash_we_n, flash_byte_n, flash_reset_n;
  logic ready_busy;
  logic [2:0] cmd_code = 3'h0;
  logic [20:0] cmd_addr = 21'h0;
  logic [15:0] cmd_data = 16'h0, rsp_data, dq_in, dq_out, rv, pv;
  logic [19:0] flash_addr;
  logic [20:0] qa [6] = '{21'h10, 21'h11, 21'h12, 21'h1f, 21'h23, 21'h2c};
  logic [15:0] qd [6] = '{16'h51, 16'h52, 16'h59, 16'h04, 16'h05, 16'h04};
  int bad_count = 0, n_compared = 0;
  always #50 clk = ~clk;
  flash_host_ctrl #(.RESUME_GAP(20)) DUT (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_code,
    .cmd_addr, .cmd_data, .byte_mode, .rsp_valid, .rsp_data, .suspended, .resume_hold,
    .pair_limit, .fail_recovering, .flash_addr, .flash_addr_lsb, .flash_ce_n, .flash_oe_n,
    .flash_we_n, .flash_byte_n, .flash_reset_n, .dq_in, .dq_out, .dq_oe,
    .ready_busy_in(ready_busy));
  flash_dev_model u_flash (.flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_byte_n,
    .dq_out, .dq_oe, .dq_in, .ready_busy, .erasing, .fail_en, .id_hv);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic op(input logic [2:0] c, input logic [20:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #10;
    cmd_code = c;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #10;
      n++;
    end
    if (n >= 100) bad_count++;
    @(posedge clk);
    #10;
    cmd_valid = 1'b0;
  endtask
  task automatic rd(input logic [20:0] a, input logic [15:0] exp, input logic [15:0] m);
    int n;
    n = 0;
    op(flash_host_pkg::CMD_READ, a, 16'h0);
    while (rsp_valid !== 1'b1 && n < 50) begin
      @(posedge clk);
      #10;
      n++;
    end
    if (n >= 50) bad_count++;
    pv = rv;
    rv = rsp_data;
    chk("rsp_data", rv & m, exp);
  endtask
  task automatic refused;
    cmd_code = flash_host_pkg::CMD_SUSPEND;
    #1;
    chk("cmd_ready", {15'h0, cmd_ready}, 16'h0);
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #8000000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    #10 rst = 1'b0;
    chk("cmd_ready", {15'h0, cmd_ready}, 16'h1);
    op(flash_host_pkg::CMD_PROGRAM, 21'h40, 16'h1234);
    op(flash_host_pkg::CMD_RESET, 21'h0, 16'h0);
    rd(21'h40, 16'h0080, 16'h00a0);
    repeat (60) @(posedge clk);
    rd(21'h40, 16'h1234, 16'hffff);
    $display("program test done");
    op(flash_host_pkg::CMD_ID_ENTRY, 21'h0, 16'h0);
    rd(21'h0, 16'h005a, 16'hffff);
    rd(21'h1, 16'h003c, 16'hffff);
    rd(21'h03002, 16'h0001, 16'hffff);
    rd(21'h04002, 16'h0000, 16'hffff);
    op(flash_host_pkg::CMD_PROGRAM, 21'h0, 16'h0);
    rd(21'h0, 16'h005a, 16'hffff);
    op(flash_host_pkg::CMD_QUERY_ENTRY, 21'h0, 16'h0);
    rd(21'h10, 16'h0051, 16'hffff);
    op(flash_host_pkg::CMD_RESET, 21'h0, 16'h0);
    rd(21'h1, 16'h003c, 16'hffff);
    op(flash_host_pkg::CMD_RESET, 21'h0, 16'h0);
    rd(21'h40, 16'h1234, 16'hffff);
    id_hv = 1'b1;
    rd(21'h1, 16'h003c, 16'hffff);
    id_hv = 1'b0;
    rd(21'h40, 16'h1234, 16'hffff);
    $display("identification test done");
    op(flash_host_pkg::CMD_QUERY_ENTRY, 21'h0, 16'h0);
    for (int i = 0; i < 6; i++) rd(qa[i], qd[i], 16'hffff);
    op(flash_host_pkg::CMD_RESET, 21'h0, 16'h0);
    byte_mode = 1'b1;
    op(flash_host_pkg::CMD_QUERY_ENTRY, 21'h0, 16'h0);
    for (int i = 0; i < 6; i++) rd({qa[i][19:0], 1'b0}, qd[i], 16'hffff);
    op(flash_host_pkg::CMD_RESET, 21'h0, 16'h0);
    byte_mode = 1'b0;
    $display("query test done");
    erasing = 1'b1;
    op(flash_host_pkg::CMD_SUSPEND, 21'h05000, 16'h0);
    rd(21'h05000, 16'h0080, 16'h00c0);
    rd(21'h05000, 16'h0080, 16'h00c0);
    chk("sector toggle", {15'h0, rv[2] ^ pv[2]}, 16'h1);
    chk("suspended", {15'h0, suspended}, 16'h1);
    rd(21'h40, 16'h1234, 16'hffff);
    op(flash_host_pkg::CMD_RESUME, 21'h05000, 16'h0);
    repeat (8) @(posedge clk);
    #10;
    chk("resume_hold", {15'h0, resume_hold}, 16'h1);
    chk("suspended", {15'h0, suspended}, 16'h0);
    refused;
    for (int i = 0; i < 1023; i++) begin
      op(flash_host_pkg::CMD_SUSPEND, 21'h05000, 16'h0);
      op(flash_host_pkg::CMD_RESUME, 21'h05000, 16'h0);
    end
    repeat (30) @(posedge clk);
    #10;
    chk("pair_limit", {15'h0, pair_limit}, 16'h1);
    refused;
    erasing = 1'b0;
    repeat (30) @(posedge clk);
    #10;
    chk("pair_limit", {15'h0, pair_limit}, 16'h0);
    $display("suspend test done");
    fail_en = 1'b1;
    op(flash_host_pkg::CMD_PROGRAM, 21'h41, 16'h00ff);
    rd(21'h41, 16'h0020, 16'h0020);
    fail_en = 1'b0;
    repeat (40) @(posedge clk);
    #10;
    chk("fail_recovering", {15'h0, fail_recovering}, 16'h0);
    rd(21'h40, 16'h1234, 16'hffff);
    $display("failure test done");
    stop_test;
  end
endmodule // flash_host_ctrl_tb
